// File: verilog/dlm_monitor.sv
// Skip-band shaping, level detectors, timers and register port of the drive level monitor.
// What this block does
// - Commanded frequency inside a skip band is replaced by the nearer band boundary.
// - Two skip points share one range; zero point inactive, both zero disables.
// - Skip-during-ramp select makes the ramping frequency jump across the band.
// - Frequency-detect flag sets above level, clears below level minus hysteresis.
// - Each detect channel has its own hysteresis percent; defaults 50.00Hz and 5.0%.
// - Reached flag while running frequency is within percent-of-max band of target.
// - Two arbitrary-frequency flags while frequency is within amplitude of value.
// - Zero-current flag after current stays at or below level longer than delay.
// - Overcurrent flag after current stays at or above threshold; zero disables.
// - Two arbitrary-current flags while current is within amplitude of its level.
// - Run-time flag when time since current start reaches the setting, in tenths of a minute.
// - Power-on flag when accumulated powered hours reach the threshold.
// - Running-time flag when accumulated running hours reach the threshold.
// - Timed-run duration from setting, or analog input one scaled across setting.
// - Timed run restarts at each start, stops drive and flags on expiry.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "dlm_defines.svh"
module dlm_monitor
	import dlm_pkg::*;
#(
	parameter int TICK_CYCLES = `DLM_TICK_US * `DLM_CLK_MHZ,
	parameter int TICKS_PER_CS = `DLM_CS_US / `DLM_TICK_US,
	parameter int TICKS_PER_TENTH_MIN = `DLM_TENTH_MIN_US / `DLM_TICK_US
)
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rd_data_o,
	input wire logic [15:0] target_freq_i,
	input wire logic [15:0] ramp_freq_i,
	input wire logic [15:0] out_current_i,
	input wire logic running_i,
	input wire logic [15:0] analog_input_one_i,
	input wire logic [15:0] accumulated_power_on_hours_i,
	input wire logic [15:0] accumulated_run_hours_i,
	output logic [15:0] run_freq_o,
	output logic [15:0] skip_target_o,
	output logic [12:0] flags_o,
	output logic timed_stop_o,
	output logic irq_o
);
	logic [2:0] ctrl_r;
	dlm_freq_type skip_pt_r [2];
	dlm_freq_type skip_range_r;
	dlm_freq_type det_level_r [2];
	dlm_pct_type det_hyst_r [2];
	dlm_pct_type reach_amp_r;
	dlm_freq_type max_freq_r;
	dlm_freq_type anyf_val_r [2];
	dlm_pct_type anyf_amp_r [2];
	dlm_pct_type qual_level_r [2];
	logic [15:0] qual_dly_r [2];
	dlm_pct_type anyc_level_r [2];
	dlm_pct_type anyc_amp_r [2];
	logic [15:0] run_set_r;
	logic [15:0] pwr_set_r;
	logic [15:0] racc_set_r;
	dlm_tenth_min_type timed_dur_r;
	dlm_flag_type int_stat_r;
	dlm_flag_type int_mask_r;
	dlm_flag_type flags_nxt;
	dlm_flag_type int_stat_nxt;
	logic [$clog2(TICK_CYCLES + 1)-1:0] tick_cnt_r;
	logic tick_r;
	logic [$clog2(TICKS_PER_TENTH_MIN + 1)-1:0] tenth_cnt_r;
	dlm_tenth_min_type elapsed_r;
	dlm_tenth_min_type timed_limit;
	logic running_d_r;
	logic start_pulse;
	logic [23:0] qual_cnt_r [2];
	logic qual_cond [2];
	logic qual_flag_r [2];
	dlm_freq_type skip_target_nxt;
	dlm_freq_type run_freq_nxt;
	dlm_freq_type hyst_freq [2];

	function automatic logic [16:0] band_hi(input logic [15:0] p, input logic [15:0] r);
		band_hi = {1'b0, p} + {1'b0, r};
	endfunction

	function automatic logic [15:0] band_lo(input logic [15:0] p, input logic [15:0] r);
		band_lo = (p > r) ? p - r : 16'h0000;
	endfunction

	function automatic logic in_band(input logic [15:0] f, input logic [15:0] p,
		input logic [15:0] r);
		in_band = (p != 16'h0000) && (f > band_lo(p, r)) && ({1'b0, f} < band_hi(p, r));
	endfunction

	function automatic logic [15:0] sat16(input logic [16:0] v);
		sat16 = v[16] ? 16'hFFFF : v[15:0];
	endfunction

	function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
		abs_diff = (a > b) ? a - b : b - a;
	endfunction

	function automatic logic [15:0] pct_of(input logic [15:0] base, input logic [15:0] pct);
		logic [31:0] prod;
		prod = 32'(base) * 32'(pct);
		pct_of = 16'(prod / `DLM_PCT_FULL);
	endfunction

	// Free-running control tick.
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tick_cnt_r <= '0;
			tick_r <= 1'b0;
		end
		else if (tick_cnt_r == ($bits(tick_cnt_r))'(TICK_CYCLES - 1))
		begin
			tick_cnt_r <= '0;
			tick_r <= 1'b1;
		end
		else
		begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
			tick_r <= 1'b0;
		end
	end

	// Skip bands are applied to the commanded and to the ramping frequency.
	always_comb
	begin
		skip_target_nxt = target_freq_i;
		for (int i = 0; i < 2; i++)
		begin
			if (in_band(skip_target_nxt, skip_pt_r[i], skip_range_r))
			begin
				if ((skip_target_nxt - band_lo(skip_pt_r[i], skip_range_r)) <=
					(sat16(band_hi(skip_pt_r[i], skip_range_r)) - skip_target_nxt))
					skip_target_nxt = band_lo(skip_pt_r[i], skip_range_r);
				else
					skip_target_nxt = sat16(band_hi(skip_pt_r[i], skip_range_r));
			end
		end
		run_freq_nxt = ramp_freq_i;
		for (int i = 0; i < 2; i++)
		begin
			if (ctrl_r[`DLM_CTRL_SKIP_RAMP] && in_band(run_freq_nxt, skip_pt_r[i], skip_range_r))
			begin
				if (run_freq_nxt < skip_target_nxt)
					run_freq_nxt = sat16(band_hi(skip_pt_r[i], skip_range_r));
				else
					run_freq_nxt = band_lo(skip_pt_r[i], skip_range_r);
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			skip_target_o <= 16'h0000;
			run_freq_o <= 16'h0000;
		end
		else if (tick_r)
		begin
			skip_target_o <= skip_target_nxt;
			run_freq_o <= run_freq_nxt;
		end
	end

	// Delay-qualified current detectors: zero current and overcurrent.
	assign qual_cond[0] = out_current_i <= qual_level_r[0];
	assign qual_cond[1] = (qual_level_r[1] != 16'h0000) && (out_current_i >= qual_level_r[1]);

	for (genvar g = 0; g < 2; g++)
	begin : g_qual
		logic [23:0] lim;
		assign lim = 24'(qual_dly_r[g]) * 24'(TICKS_PER_CS);
		always_ff @(posedge clock_i or posedge rst_i)
		begin
			if (rst_i)
			begin
				qual_cnt_r[g] <= '0;
				qual_flag_r[g] <= 1'b0;
			end
			else if (!qual_cond[g])
			begin
				qual_cnt_r[g] <= '0;
				qual_flag_r[g] <= 1'b0;
			end
			else if (tick_r)
			begin
				if (qual_cnt_r[g] >= lim)
					qual_flag_r[g] <= 1'b1;
				else
					qual_cnt_r[g] <= qual_cnt_r[g] + 24'h000001;
			end
		end
	end

	// Elapsed run time since the latest start, in tenths of a minute.
	assign start_pulse = running_i && !running_d_r;
	assign timed_limit = ctrl_r[`DLM_CTRL_TIMED_SRC] ?
		20'((36'(timed_dur_r) * 36'(analog_input_one_i)) >> 16) : timed_dur_r;

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			running_d_r <= 1'b0;
			tenth_cnt_r <= '0;
			elapsed_r <= '0;
		end
		else
		begin
			running_d_r <= running_i;
			if (start_pulse)
			begin
				tenth_cnt_r <= '0;
				elapsed_r <= '0;
			end
			else if (running_i && tick_r)
			begin
				if (tenth_cnt_r == ($bits(tenth_cnt_r))'(TICKS_PER_TENTH_MIN - 1))
				begin
					tenth_cnt_r <= '0;
					if (elapsed_r != 20'hFFFFF)
						elapsed_r <= elapsed_r + 20'h00001;
				end
				else
					tenth_cnt_r <= tenth_cnt_r + 1'b1;
			end
		end
	end

	// Level flags.
	for (genvar g = 0; g < 2; g++)
	begin : g_hyst
		assign hyst_freq[g] = pct_of(det_level_r[g], det_hyst_r[g]);
	end

	always_comb
	begin
		flags_nxt = flags_o;
		for (int i = 0; i < 2; i++)
		begin
			if (run_freq_o > det_level_r[i])
				flags_nxt[`DLM_F_FREQ_DETECT_LEVEL_ONE + i] = 1'b1;
			else if ({1'b0, run_freq_o} + {1'b0, hyst_freq[i]} < {1'b0, det_level_r[i]})
				flags_nxt[`DLM_F_FREQ_DETECT_LEVEL_ONE + i] = 1'b0;
			flags_nxt[`DLM_F_ANYF1 + i] = abs_diff(run_freq_o, anyf_val_r[i]) <=
				pct_of(max_freq_r, anyf_amp_r[i]);
			flags_nxt[`DLM_F_ANYC1 + i] = abs_diff(out_current_i, anyc_level_r[i]) <=
				anyc_amp_r[i];
		end
		flags_nxt[`DLM_F_REACH] = running_i &&
			(abs_diff(run_freq_o, skip_target_o) <= pct_of(max_freq_r, reach_amp_r));
		flags_nxt[`DLM_F_ZERO] = qual_flag_r[0];
		flags_nxt[`DLM_F_OVER] = qual_flag_r[1];
		// A start restarts the timers, so the stale count of the last run must not flag here.
		flags_nxt[`DLM_F_RUNT] = running_i && !start_pulse && (run_set_r != 16'h0000) &&
			(elapsed_r >= 20'(run_set_r));
		flags_nxt[`DLM_F_PWR] = (pwr_set_r != 16'h0000) &&
			(accumulated_power_on_hours_i >= pwr_set_r);
		flags_nxt[`DLM_F_RACC] = (racc_set_r != 16'h0000) &&
			(accumulated_run_hours_i >= racc_set_r);
		flags_nxt[`DLM_F_TIMED] = ctrl_r[`DLM_CTRL_TIMED_EN] && running_i && !start_pulse &&
			(timed_limit != 20'h00000) && (elapsed_r >= timed_limit);
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			flags_o <= '0;
			timed_stop_o <= 1'b0;
		end
		else if (tick_r)
		begin
			flags_o <= flags_nxt;
			timed_stop_o <= flags_nxt[`DLM_F_TIMED];
		end
	end

	// Sticky interrupt status; a new rising flag wins over a write-one clear.
	always_comb
	begin
		int_stat_nxt = int_stat_r;
		if (wr_i && addr_i == `DLM_OFF_INT_STAT)
			int_stat_nxt = int_stat_nxt & ~wr_data_i[12:0];
		if (tick_r)
			int_stat_nxt = int_stat_nxt | (flags_nxt & ~flags_o);
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			int_stat_r <= '0;
			irq_o <= 1'b0;
		end
		else
		begin
			int_stat_r <= int_stat_nxt;
			irq_o <= |(int_stat_nxt & int_mask_r);
		end
	end

	// Register writes.
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ctrl_r <= 3'h0;
			skip_pt_r <= '{16'h0000, 16'h0000};
			skip_range_r <= `DLM_RST_SKIP_RANGE;
			det_level_r <= '{`DLM_RST_FREQ_LEVEL, `DLM_RST_FREQ_LEVEL};
			det_hyst_r <= '{`DLM_RST_HYST, `DLM_RST_HYST};
			reach_amp_r <= 16'h0000;
			max_freq_r <= `DLM_RST_MAX_FREQ;
			anyf_val_r <= '{`DLM_RST_FREQ_LEVEL, `DLM_RST_FREQ_LEVEL};
			anyf_amp_r <= '{16'h0000, 16'h0000};
			qual_level_r <= '{`DLM_RST_ZERO_LEVEL, `DLM_RST_OVER_LEVEL};
			qual_dly_r <= '{`DLM_RST_ZERO_DLY, `DLM_RST_OVER_DLY};
			anyc_level_r <= '{`DLM_RST_CUR_LEVEL, `DLM_RST_CUR_LEVEL};
			anyc_amp_r <= '{16'h0000, 16'h0000};
			run_set_r <= 16'h0000;
			pwr_set_r <= 16'h0000;
			racc_set_r <= 16'h0000;
			timed_dur_r <= 20'h00000;
			int_mask_r <= '0;
		end
		else if (wr_i)
		begin
			unique case (addr_i)
				`DLM_OFF_CTRL: ctrl_r <= wr_data_i[2:0];
				`DLM_OFF_SKIP_PTS: skip_pt_r <= '{wr_data_i[15:0], wr_data_i[31:16]};
				`DLM_OFF_SKIP_RANGE: skip_range_r <= wr_data_i[15:0];
				`DLM_OFF_FREQ_DETECT_LEVEL_ONE: {det_hyst_r[0], det_level_r[0]} <= wr_data_i;
				`DLM_OFF_FREQ_DETECT_LEVEL_TWO: {det_hyst_r[1], det_level_r[1]} <= wr_data_i;
				`DLM_OFF_REACH: {max_freq_r, reach_amp_r} <= wr_data_i;
				`DLM_OFF_ANYF1: {anyf_amp_r[0], anyf_val_r[0]} <= wr_data_i;
				`DLM_OFF_ANYF2: {anyf_amp_r[1], anyf_val_r[1]} <= wr_data_i;
				`DLM_OFF_ZERO_CUR: {qual_dly_r[0], qual_level_r[0]} <= wr_data_i;
				`DLM_OFF_OVER_CUR: {qual_dly_r[1], qual_level_r[1]} <= wr_data_i;
				`DLM_OFF_ANYC1: {anyc_amp_r[0], anyc_level_r[0]} <= wr_data_i;
				`DLM_OFF_ANYC2: {anyc_amp_r[1], anyc_level_r[1]} <= wr_data_i;
				`DLM_OFF_RUN_SET: run_set_r <= wr_data_i[15:0];
				`DLM_OFF_PWR_SET: pwr_set_r <= wr_data_i[15:0];
				`DLM_OFF_RACC_SET: racc_set_r <= wr_data_i[15:0];
				`DLM_OFF_TIMED_DUR: timed_dur_r <= wr_data_i[19:0];
				`DLM_OFF_INT_MASK: int_mask_r <= wr_data_i[12:0];
				default: ;
			endcase
		end
	end

	// Register reads; unmapped offsets read zero.
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			rd_data_o <= 32'h00000000;
		else if (rd_i)
		begin
			unique case (addr_i)
				`DLM_OFF_CTRL: rd_data_o <= {29'h0, ctrl_r};
				`DLM_OFF_SKIP_PTS: rd_data_o <= {skip_pt_r[1], skip_pt_r[0]};
				`DLM_OFF_SKIP_RANGE: rd_data_o <= {16'h0000, skip_range_r};
				`DLM_OFF_FREQ_DETECT_LEVEL_ONE: rd_data_o <= {det_hyst_r[0], det_level_r[0]};
				`DLM_OFF_FREQ_DETECT_LEVEL_TWO: rd_data_o <= {det_hyst_r[1], det_level_r[1]};
				`DLM_OFF_REACH: rd_data_o <= {max_freq_r, reach_amp_r};
				`DLM_OFF_ANYF1: rd_data_o <= {anyf_amp_r[0], anyf_val_r[0]};
				`DLM_OFF_ANYF2: rd_data_o <= {anyf_amp_r[1], anyf_val_r[1]};
				`DLM_OFF_ZERO_CUR: rd_data_o <= {qual_dly_r[0], qual_level_r[0]};
				`DLM_OFF_OVER_CUR: rd_data_o <= {qual_dly_r[1], qual_level_r[1]};
				`DLM_OFF_ANYC1: rd_data_o <= {anyc_amp_r[0], anyc_level_r[0]};
				`DLM_OFF_ANYC2: rd_data_o <= {anyc_amp_r[1], anyc_level_r[1]};
				`DLM_OFF_RUN_SET: rd_data_o <= {16'h0000, run_set_r};
				`DLM_OFF_PWR_SET: rd_data_o <= {16'h0000, pwr_set_r};
				`DLM_OFF_RACC_SET: rd_data_o <= {16'h0000, racc_set_r};
				`DLM_OFF_TIMED_DUR: rd_data_o <= {12'h000, timed_dur_r};
				`DLM_OFF_FLAGS: rd_data_o <= {19'h0, flags_o};
				`DLM_OFF_INT_STAT: rd_data_o <= {19'h0, int_stat_r};
				`DLM_OFF_INT_MASK: rd_data_o <= {19'h0, int_mask_r};
				`DLM_OFF_RUN_FREQ: rd_data_o <= {skip_target_o, run_freq_o};
				`DLM_OFF_ELAPSED: rd_data_o <= {12'h000, elapsed_r};
				default: rd_data_o <= 32'h00000000;
			endcase
		end
	end

	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);

	AST_SKIP_NEAR: assert property (
		tick_r && in_band(target_freq_i, skip_pt_r[0], skip_range_r) && skip_pt_r[1] == 16'h0000
		|=> skip_target_o == band_lo($past(skip_pt_r[0]), $past(skip_range_r))
			|| skip_target_o == sat16(band_hi($past(skip_pt_r[0]), $past(skip_range_r))))
		else $error("Skipped target is not a band boundary.");
	AST_SKIP_OFF: assert property (
		tick_r && skip_pt_r[0] == 16'h0000 && skip_pt_r[1] == 16'h0000
		|=> skip_target_o == $past(target_freq_i))
		else $error("Target changed although skipping is off.");
	AST_RAMP_JUMP: assert property (
		tick_r && ctrl_r[`DLM_CTRL_SKIP_RAMP] && skip_pt_r[1] == 16'h0000
		|=> !in_band(run_freq_o, $past(skip_pt_r[0]), $past(skip_range_r)))
		else $error("Ramping frequency sits inside a skip band.");
	AST_FDT_SET: assert property (
		tick_r && run_freq_o > det_level_r[0] |=> flags_o[`DLM_F_FREQ_DETECT_LEVEL_ONE])
		else $error("Frequency detect flag did not set.");
	AST_FDT_HOLD: assert property (
		tick_r && flags_o[`DLM_F_FREQ_DETECT_LEVEL_ONE]
			&& {1'b0, run_freq_o} + {1'b0, hyst_freq[0]} >= {1'b0, det_level_r[0]}
		|=> flags_o[`DLM_F_FREQ_DETECT_LEVEL_ONE])
		else $error("Frequency detect flag cleared inside hysteresis.");
	AST_REACH_IDLE: assert property (
		tick_r && !running_i |=> !flags_o[`DLM_F_REACH])
		else $error("Reached flag while stopped.");
	AST_ZERO_DROP: assert property (
		!qual_cond[0] ##1 tick_r |=> !flags_o[`DLM_F_ZERO])
		else $error("Zero current flag outlived its condition.");
	AST_OVER_OFF: assert property (
		qual_level_r[1] == 16'h0000 ##1 tick_r |=> !flags_o[`DLM_F_OVER])
		else $error("Overcurrent flag with detection disabled.");
	AST_TIMED_PAIR: assert property (
		timed_stop_o == flags_o[`DLM_F_TIMED])
		else $error("Timed stop and timed flag disagree.");
	AST_START_CLEAR: assert property (
		start_pulse |=> elapsed_r == 20'h00000)
		else $error("Elapsed time not cleared at start.");
	AST_TICK_PERIOD: assert property (
		tick_r |=> !tick_r)
		else $error("Tick longer than one cycle.");
endmodule

// File: verilog/dlm_defines.svh
// Register offsets, field positions, reset values and timing counts of the drive level monitor.
`ifndef DLM_DEFINES_SVH
`define DLM_DEFINES_SVH

`define DLM_OFF_CTRL 8'h00
`define DLM_OFF_SKIP_PTS 8'h04
`define DLM_OFF_SKIP_RANGE 8'h08
`define DLM_OFF_FREQ_DETECT_LEVEL_ONE 8'h0C
`define DLM_OFF_FREQ_DETECT_LEVEL_TWO 8'h10
`define DLM_OFF_REACH 8'h14
`define DLM_OFF_ANYF1 8'h18
`define DLM_OFF_ANYF2 8'h1C
`define DLM_OFF_ZERO_CUR 8'h20
`define DLM_OFF_OVER_CUR 8'h24
`define DLM_OFF_ANYC1 8'h28
`define DLM_OFF_ANYC2 8'h2C
`define DLM_OFF_RUN_SET 8'h30
`define DLM_OFF_PWR_SET 8'h34
`define DLM_OFF_RACC_SET 8'h38
`define DLM_OFF_TIMED_DUR 8'h3C
`define DLM_OFF_FLAGS 8'h40
`define DLM_OFF_INT_STAT 8'h44
`define DLM_OFF_INT_MASK 8'h48
`define DLM_OFF_RUN_FREQ 8'h4C
`define DLM_OFF_ELAPSED 8'h50

`define DLM_CTRL_SKIP_RAMP 0
`define DLM_CTRL_TIMED_EN 1
`define DLM_CTRL_TIMED_SRC 2

`define DLM_F_FREQ_DETECT_LEVEL_ONE 0
`define DLM_F_FREQ_DETECT_LEVEL_TWO 1
`define DLM_F_REACH 2
`define DLM_F_ANYF1 3
`define DLM_F_ANYF2 4
`define DLM_F_ZERO 5
`define DLM_F_OVER 6
`define DLM_F_ANYC1 7
`define DLM_F_ANYC2 8
`define DLM_F_RUNT 9
`define DLM_F_PWR 10
`define DLM_F_RACC 11
`define DLM_F_TIMED 12
`define DLM_NFLAG 13

`define DLM_RST_FREQ_LEVEL 16'h1388
`define DLM_RST_HYST 16'h0032
`define DLM_RST_MAX_FREQ 16'h1388
`define DLM_RST_SKIP_RANGE 16'h0001
`define DLM_RST_ZERO_LEVEL 16'h0032
`define DLM_RST_ZERO_DLY 16'h000A
`define DLM_RST_OVER_LEVEL 16'h07D0
`define DLM_RST_OVER_DLY 16'h0000
`define DLM_RST_CUR_LEVEL 16'h03E8

`define DLM_PCT_FULL 1000
`define DLM_CLK_MHZ 125
`define DLM_TICK_US 1000
`define DLM_CS_US 10000
`define DLM_TENTH_MIN_US 6000000

`endif

// File: verilog/dlm_pkg.sv
// Types shared by the drive level monitor.
package dlm_pkg;
	typedef logic [15:0] dlm_freq_type;
	typedef logic [15:0] dlm_pct_type;
	typedef logic [19:0] dlm_tenth_min_type;
	typedef logic [12:0] dlm_flag_type;
endpackage

// File: test/dlm_core_model.sv
// Drive core model that presents frequency, current, run state and hour counters.
`timescale 1ns/1ps
module dlm_core_model
(
	input wire logic clock_i,
	input wire logic [15:0] tgt_i,
	input wire logic [15:0] ramp_i,
	input wire logic [15:0] cur_i,
	input wire logic run_i,
	input wire logic [15:0] ai_i,
	input wire logic [15:0] pwr_i,
	input wire logic [15:0] rh_i,
	output logic [15:0] tgt_o,
	output logic [15:0] ramp_o,
	output logic [15:0] cur_o,
	output logic run_o,
	output logic [15:0] ai_o,
	output logic [15:0] pwr_o,
	output logic [15:0] rh_o
);
	// The core publishes its levels on the rising edge, one cycle after the request.
	always_ff @(posedge clock_i)
	begin
		tgt_o <= tgt_i;
		ramp_o <= ramp_i;
		cur_o <= cur_i;
		run_o <= run_i;
		ai_o <= ai_i;
		pwr_o <= pwr_i;
		rh_o <= rh_i;
	end
endmodule

// File: test/dlm_monitor_bench.sv
// Self-checking bench of the drive level monitor with its drive core model.
`timescale 1ns/1ps
module dlm_monitor_bench;
	localparam int TK = 4;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [31:0] rdat;
	logic [15:0] s_tgt = 16'h0, s_ramp = 16'h0, s_cur = 16'h03E8, s_ai = 16'h0;
	logic [15:0] s_pwr = 16'h0, s_rh = 16'h0;
	logic s_run = 1'b0;
	logic [15:0] tgt, ramp, cur, ai, pwr, rh, run_freq, skip_tgt;
	logic run, timed_stop, irq;
	logic [12:0] flags;
	logic [31:0] d;
	int fail_count = 0;
	int checks_done = 0;
	initial
	begin
		forever #4 clk = ~clk;
	end
	dlm_core_model i_core (.clock_i(clk), .tgt_i(s_tgt), .ramp_i(s_ramp), .cur_i(s_cur),
		.run_i(s_run), .ai_i(s_ai), .pwr_i(s_pwr), .rh_i(s_rh), .tgt_o(tgt), .ramp_o(ramp),
		.cur_o(cur), .run_o(run), .ai_o(ai), .pwr_o(pwr), .rh_o(rh));
	dlm_monitor #(.TICK_CYCLES(TK), .TICKS_PER_CS(2), .TICKS_PER_TENTH_MIN(3)) i_dut (
		.clock_i(clk), .rst_i(rst), .addr_i(addr), .wr_data_i(wdat), .wr_i(wr_s),
		.rd_i(rd_s), .rd_data_o(rdat), .target_freq_i(tgt), .ramp_freq_i(ramp),
		.out_current_i(cur), .running_i(run), .analog_input_one_i(ai),
		.accumulated_power_on_hours_i(pwr), .accumulated_run_hours_i(rh),
		.run_freq_o(run_freq), .skip_target_o(skip_tgt), .flags_o(flags),
		.timed_stop_o(timed_stop), .irq_o(irq));
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t: value %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp, input int n);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t: signal %0d is %b, expected %b", $time, n, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdat <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		v = rdat;
	endtask
	// Waits n ticks plus margin for the model delay and the tick phase.
	task automatic settle(input int n);
		repeat (n * TK + TK + 3) @(posedge clk);
		#1;
	endtask
	task automatic t_regs();
		rd(8'h0C, d); check_word(d, 32'h00321388);
		rd(8'h10, d); check_word(d, 32'h00321388);
		rd(8'h18, d); check_word(d[15:0], 32'h1388);
		rd(8'h20, d); check_word(d, 32'h000A0032);
		rd(8'h24, d); check_word(d, 32'h000007D0);
		rd(8'h28, d); check_word(d, 32'h000003E8);
		wr(8'h60, 32'hFFFFFFFF);
		rd(8'h60, d); check_word(d, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_skip();
		wr(8'h08, 32'h64);
		s_tgt <= 16'h0B86;
		settle(2); check_word(skip_tgt, 16'h0B86);
		wr(8'h04, 32'h0BB8);
		settle(2); check_word(skip_tgt, 16'h0B54);
		s_tgt <= 16'h0BF4;
		settle(2); check_word(skip_tgt, 16'h0C1C);
		wr(8'h04, 32'h0FA00000);
		s_tgt <= 16'h0F6E;
		settle(2); check_word(skip_tgt, 16'h0F3C);
		s_tgt <= 16'h0B86;
		settle(2); check_word(skip_tgt, 16'h0B86);
		wr(8'h04, 32'h0BB8);
		wr(8'h00, 32'h1);
		s_tgt <= 16'h0DAC;
		s_ramp <= 16'h0BCC;
		settle(2); check_word(run_freq, 16'h0C1C);
		s_tgt <= 16'h09C4;
		s_ramp <= 16'h0BA4;
		settle(2); check_word(run_freq, 16'h0B54);
		wr(8'h00, 32'h0);
		settle(2); check_word(run_freq, 16'h0BA4);
		wr(8'h04, 32'h0);
		$display("test skip done");
	endtask
	task automatic t_freq();
		wr(8'h0C, 32'h00320FA0);
		wr(8'h10, 32'h00C80FA0);
		s_ramp <= 16'h1004;
		settle(2); check_bit(flags[0], 1'b1, 0);
		check_bit(flags[1], 1'b1, 1);
		s_ramp <= 16'h0F3C;
		settle(2); check_bit(flags[0], 1'b1, 0);
		s_ramp <= 16'h0E74;
		settle(2); check_bit(flags[0], 1'b0, 0);
		s_ramp <= 16'h0CE4;
		settle(2); check_bit(flags[1], 1'b1, 1);
		s_ramp <= 16'h0C1C;
		settle(2); check_bit(flags[1], 1'b0, 1);
		s_run <= 1'b1;
		s_tgt <= 16'h0BB8;
		wr(8'h14, 32'h1388000A);
		s_ramp <= 16'h0BE0;
		settle(2); check_bit(flags[2], 1'b1, 2);
		s_ramp <= 16'h0C1C;
		settle(2); check_bit(flags[2], 1'b0, 2);
		wr(8'h18, 32'h000A07D0);
		s_ramp <= 16'h07EE;
		settle(2); check_bit(flags[3], 1'b1, 3);
		check_bit(flags[4], 1'b0, 4);
		s_ramp <= 16'h0834;
		settle(2); check_bit(flags[3], 1'b0, 3);
		s_run <= 1'b0;
		$display("test frequency done");
	endtask
	task automatic t_current();
		wr(8'h48, 32'h20);
		wr(8'h44, 32'h1FFF);
		s_cur <= 16'h0028;
		settle(0); check_bit(flags[5], 1'b0, 5);
		settle(17); check_bit(flags[5], 1'b0, 5);
		settle(2); check_bit(flags[5], 1'b1, 5);
		check_bit(irq, 1'b1, 20);
		wr(8'h48, 32'h0);
		repeat (2) @(posedge clk);
		#1 check_bit(irq, 1'b0, 20);
		wr(8'h48, 32'h20);
		s_cur <= 16'h03F2;
		settle(2); check_bit(flags[5], 1'b0, 5);
		check_bit(irq, 1'b1, 20);
		wr(8'h44, 32'h20);
		rd(8'h44, d); check_word(d[5], 32'h0);
		#1 check_bit(irq, 1'b0, 20);
		wr(8'h28, 32'h001403E8);
		wr(8'h2C, 32'h001407D0);
		settle(2); check_bit(flags[7], 1'b1, 7);
		check_bit(flags[8], 1'b0, 8);
		s_cur <= 16'h07DA;
		settle(2); check_bit(flags[6], 1'b1, 6);
		check_bit(flags[8], 1'b1, 8);
		wr(8'h24, 32'h0);
		settle(2); check_bit(flags[6], 1'b0, 6);
		wr(8'h24, 32'h000107D0);
		settle(0); check_bit(flags[6], 1'b0, 6);
		settle(6); check_bit(flags[6], 1'b1, 6);
		s_cur <= 16'h07C6;
		settle(2); check_bit(flags[6], 1'b0, 6);
		$display("test current done");
	endtask
	task automatic t_timers();
		wr(8'h30, 32'h2);
		wr(8'h3C, 32'hA);
		wr(8'h00, 32'h2);
		wr(8'h34, 32'h64);
		wr(8'h38, 32'hC8);
		s_pwr <= 16'h0063;
		s_rh <= 16'h00C7;
		s_run <= 1'b1;
		settle(1); check_bit(flags[9], 1'b0, 9);
		check_bit(flags[10], 1'b0, 10);
		check_bit(flags[11], 1'b0, 11);
		settle(8); check_bit(flags[9], 1'b1, 9);
		check_bit(timed_stop, 1'b0, 12);
		s_pwr <= 16'h0064;
		s_rh <= 16'h00C8;
		settle(24); check_bit(timed_stop, 1'b1, 12);
		check_bit(flags[12], 1'b1, 12);
		check_bit(flags[10], 1'b1, 10);
		check_bit(flags[11], 1'b1, 11);
		s_run <= 1'b0;
		wr(8'h00, 32'h6);
		s_ai <= 16'h8000;
		settle(1);
		s_run <= 1'b1;
		settle(1); check_bit(timed_stop, 1'b0, 12);
		settle(20); check_bit(timed_stop, 1'b1, 12);
		$display("test timers done");
	endtask
	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (10000) @(posedge clk);
		fail_count++;
		$display("[FAIL] %0t: watchdog expired", $time);
		give_verdict();
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		#1 check_word({19'h0, flags}, 32'h0);
		check_bit(irq, 1'b0, 20);
		t_regs();
		t_skip();
		t_freq();
		t_current();
		t_timers();
		give_verdict();
	end
endmodule
